// file: core/meter_serial_port.sv
// Purpose: serial slave port with register map and energy accumulation of a metering core
// Assumes: sclk comes from the host and may stop outside frames; cs_b, din async to mclk
// Notes: energy and waveform inputs arrive on mclk; clear-on-read crosses by toggle
`timescale 1ns/1ps
`include "meter_map.svh"
module meter_serial_port
    import meter_pkg::*;
(
    input wire logic mclk, // System clock, 10 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic sclk, // Serial clock from host
    input wire logic cs_b, // Chip select, active low
    input wire logic din, // Serial data in, sampled on sclk falling
    output logic dout_o, // Serial data out
    output logic dout_oe, // High while dout driven
    input wire logic sample_stb, // New waveform and power sample
    input wire logic [23:0] cur_sample, // Current channel sample
    input wire logic [23:0] volt_sample, // Voltage channel sample
    input wire logic signed [23:0] active_power, // Instantaneous active power
    input wire logic [23:0] apparent_power, // Instantaneous apparent power
    input wire logic half_cycle_stb, // Zero crossing, one half line cycle
    input wire logic [15:0] line_cycle_count, // Half line cycles per line accumulation
    input wire logic [15:0] event_set, // Event pulses into status flags
    output logic irq_b, // Interrupt, active low
    output logic [15:0] config_o, // Operating configuration
    output logic [5:0] cur_offset, // Current channel offset
    output logic integrator_en, // Current channel integrator enable
    output logic [5:0] volt_offset, // Voltage offset, sign already inverted
    output logic [7:0] amp_gain, // Amplifier gain selection
    output logic [5:0] phase_cal, // Phase calibration
    output logic signed [15:0] ap_offset // Active power offset
);
    // ---------------- mclk domain: measurement state ----------------
    word24_t waveform_ff;
    logic signed [23:0] aeng_ff;
    logic [23:0] vaeng_ff;
    logic signed [23:0] laeng_acc_ff, laeng_ff;
    logic [23:0] lvaeng_acc_ff, lvaeng_ff;
    logic [15:0] hc_cnt_ff;
    flags_t flags_ff;
    logic [15:0] config_ff, evt_en_ff, apofs_ff;
    logic [7:0] cur_ofs_ff, volt_ofs_ff, gain_ff;
    logic [5:0] phase_calibration_ff;
    logic signed [23:0] corr_power;

    // Cross-domain: clear requests and write commits arrive as toggles
    logic clr_tg_s, clr_s1_ff, clr_s2_ff, clr_s3_ff;
    logic wr_tg_s, wr_s1_ff, wr_s2_ff, wr_s3_ff;
    logic [5:0] clr_addr_s, wr_addr_s;
    logic [15:0] wr_data_s;
    logic clr_pulse, wr_pulse;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clr_s1_ff <= 1'b0;
            clr_s2_ff <= 1'b0;
            clr_s3_ff <= 1'b0;
            wr_s1_ff <= 1'b0;
            wr_s2_ff <= 1'b0;
            wr_s3_ff <= 1'b0;
        end else begin
            clr_s1_ff <= clr_tg_s;
            clr_s2_ff <= clr_s1_ff;
            clr_s3_ff <= clr_s2_ff;
            wr_s1_ff <= wr_tg_s;
            wr_s2_ff <= wr_s1_ff;
            wr_s3_ff <= wr_s2_ff;
        end
    end
    // Address and data held stable by the link side until the next command byte
    assign clr_pulse = clr_s2_ff ^ clr_s3_ff;
    assign wr_pulse = wr_s2_ff ^ wr_s3_ff;

    function automatic logic is_clr(input logic [5:0] a, input logic [5:0] tgt);
        is_clr = clr_pulse && (a == tgt);
    endfunction : is_clr

    assign corr_power = active_power + 24'(signed'(apofs_ff));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_ff <= 24'h000000;
        end else if (sample_stb) begin
            case (config_ff[`CFG_WAVSRC_HI:`CFG_WAVSRC_LO])
                2'b00: waveform_ff <= corr_power;
                2'b10: waveform_ff <= cur_sample;
                2'b11: waveform_ff <= volt_sample;
                default: waveform_ff <= 24'h000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aeng_ff <= 24'sh000000;
            vaeng_ff <= 24'h000000;
        end else begin
            // Clear, then this sample's contribution, so no sample is lost
            aeng_ff <= (is_clr(clr_addr_s, `ADDR_AENG_COR) ? 24'sh000000 : aeng_ff)
                + (sample_stb ? corr_power : 24'sh000000);
            vaeng_ff <= (is_clr(clr_addr_s, `ADDR_VAENG_COR) ? 24'h000000 : vaeng_ff)
                + (sample_stb ? apparent_power : 24'h000000);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            laeng_acc_ff <= 24'sh000000;
            lvaeng_acc_ff <= 24'h000000;
            laeng_ff <= 24'sh000000;
            lvaeng_ff <= 24'h000000;
            hc_cnt_ff <= 16'h0000;
        end else if (half_cycle_stb && (hc_cnt_ff + 16'h0001 >= line_cycle_count)) begin
            laeng_ff <= laeng_acc_ff;
            lvaeng_ff <= lvaeng_acc_ff;
            laeng_acc_ff <= sample_stb ? corr_power : 24'sh000000;
            lvaeng_acc_ff <= sample_stb ? apparent_power : 24'h000000;
            hc_cnt_ff <= 16'h0000;
        end else begin
            if (sample_stb) begin
                laeng_acc_ff <= laeng_acc_ff + corr_power;
                lvaeng_acc_ff <= lvaeng_acc_ff + apparent_power;
            end
            if (half_cycle_stb) begin
                hc_cnt_ff <= hc_cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= 16'h0000;
        end else begin
            // New events win over a clear in the same cycle
            flags_ff <= (is_clr(clr_addr_s, `ADDR_EVT_FLAGS_COR) ? 16'h0000 : flags_ff) | event_set;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            config_ff <= `RST_CONFIG;
            evt_en_ff <= `RST_EVT_EN;
            cur_ofs_ff <= 8'h00;
            volt_ofs_ff <= 8'h00;
            gain_ff <= 8'h00;
            phase_calibration_ff <= `RST_PHASE_CALIBRATION;
            apofs_ff <= 16'h0000;
        end else if (wr_pulse) begin
            // Read-only and reserved addresses fall through untouched
            if (wr_addr_s == `ADDR_CONFIG) begin
                config_ff <= wr_data_s;
            end else if (wr_addr_s == `ADDR_EVT_EN) begin
                evt_en_ff <= wr_data_s;
            end else if (wr_addr_s == `ADDR_CUR_OFS) begin
                cur_ofs_ff <= {wr_data_s[7], 1'b0, wr_data_s[5:0]};
            end else if (wr_addr_s == `ADDR_VOLT_OFS) begin
                volt_ofs_ff <= {2'b00, wr_data_s[5:0]};
            end else if (wr_addr_s == `ADDR_GAIN) begin
                gain_ff <= wr_data_s[7:0];
            end else if (wr_addr_s == `ADDR_PHASE_CALIBRATION) begin
                phase_calibration_ff <= wr_data_s[5:0];
            end else if (wr_addr_s == `ADDR_APOFS) begin
                apofs_ff <= wr_data_s;
            end
        end
    end

    logic irq_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flags_ff & evt_en_ff);
        end
    end
    assign irq_b = ~irq_ff;
    assign config_o = config_ff;
    assign cur_offset = cur_ofs_ff[5:0];
    assign integrator_en = cur_ofs_ff[`CUR_OFS_INTEG_BIT];
    assign volt_offset = 6'(-signed'(volt_ofs_ff[5:0]));
    assign amp_gain = gain_ff;
    assign phase_cal = phase_calibration_ff;
    assign ap_offset = apofs_ff;

    // Register snapshot source; multi-bit values are quasi-static or sampled once per command
    function automatic logic [23:0] reg_value(input logic [5:0] a);
        if (a == `ADDR_WAVEFORM) reg_value = waveform_ff;
        else if (a == `ADDR_AENG || a == `ADDR_AENG_COR) reg_value = aeng_ff;
        else if (a == `ADDR_LAENG) reg_value = laeng_ff;
        else if (a == `ADDR_VAENG || a == `ADDR_VAENG_COR) reg_value = vaeng_ff;
        else if (a == `ADDR_LVAENG) reg_value = lvaeng_ff;
        else if (a == `ADDR_CONFIG) reg_value = {8'h00, config_ff};
        else if (a == `ADDR_EVT_EN) reg_value = {8'h00, evt_en_ff};
        else if (a == `ADDR_EVT_FLAGS || a == `ADDR_EVT_FLAGS_COR) reg_value = {8'h00, flags_ff};
        else if (a == `ADDR_CUR_OFS) reg_value = {16'h0000, cur_ofs_ff};
        else if (a == `ADDR_VOLT_OFS) reg_value = {16'h0000, volt_ofs_ff};
        else if (a == `ADDR_GAIN) reg_value = {16'h0000, gain_ff};
        else if (a == `ADDR_PHASE_CALIBRATION) reg_value = {18'h00000, phase_calibration_ff};
        else if (a == `ADDR_APOFS) reg_value = {8'h00, apofs_ff};
        else reg_value = 24'h000000;
    endfunction : reg_value

    function automatic logic [4:0] reg_bits(input logic [5:0] a);
        if (a >= `ADDR_WAVEFORM && a <= `ADDR_LVAENG) reg_bits = 5'd24;
        else if (a == `ADDR_CONFIG || a == `ADDR_EVT_EN || a == `ADDR_EVT_FLAGS) reg_bits = 5'd16;
        else if (a == `ADDR_EVT_FLAGS_COR || a == `ADDR_APOFS) reg_bits = 5'd16;
        else reg_bits = 5'd8;
    endfunction : reg_bits

    // ---------------- sclk domain: the link ----------------
    // Chip select brought onto mclk; idles deselected so the copy refreshes after reset
    logic cs_s1_ff;
    logic cs_s2_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
        end else begin
            cs_s1_ff <= cs_b;
            cs_s2_ff <= cs_s1_ff;
        end
    end

    // Refreshed only while deselected, so the word the link loads never moves under it.
    // Limitation: a read returns the values held when its frame began.
    logic [23:0] snap_all_ff [0:63];
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 64; i++) snap_all_ff[i] <= 24'h000000;
        end else if (cs_s2_ff) begin
            for (int i = 0; i < 64; i++) snap_all_ff[i] <= reg_value(6'(i));
        end
    end

    port_phase_t phase_ff;
    logic [2:0] bit_cnt_ff;
    logic [4:0] out_left_ff;
    logic [6:0] cmd_sh_ff;
    logic [23:0] tx_sh_ff;
    logic [15:0] rx_sh_ff;
    logic [4:0] rx_left_ff;
    logic drive_ff, last_fall_ff;

    // Chip select high holds the link in reset, so the falling edge restarts it
    wire link_rst_b = rst_b & ~cs_b;
    wire read_load = (phase_ff == PH_READ) && !drive_ff && (out_left_ff == 5'd0);

    // Command byte is sampled on falling sclk
    always_ff @(negedge sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            phase_ff <= PH_CMD;
            bit_cnt_ff <= 3'd0;
            cmd_sh_ff <= 7'h00;
            rx_sh_ff <= 16'h0000;
            rx_left_ff <= 5'd0;
            last_fall_ff <= 1'b0;
        end else begin
            last_fall_ff <= 1'b0;
            case (phase_ff)
                PH_CMD: begin
                    cmd_sh_ff <= {cmd_sh_ff[5:0], din};
                    bit_cnt_ff <= bit_cnt_ff + 3'd1;
                    if (bit_cnt_ff == 3'd7) begin
                        if (cmd_sh_ff[6] == 1'b0) begin
                            phase_ff <= PH_READ;
                        end else begin
                            phase_ff <= PH_WRITE;
                            rx_left_ff <= reg_bits({cmd_sh_ff[4:0], din});
                        end
                    end
                end
                PH_READ: begin
                    if (out_left_ff == 5'd1) begin
                        phase_ff <= PH_CMD;
                        last_fall_ff <= 1'b1;
                    end
                end
                PH_WRITE: begin
                    rx_sh_ff <= {rx_sh_ff[14:0], din};
                    rx_left_ff <= rx_left_ff - 5'd1;
                    if (rx_left_ff == 5'd1) begin
                        phase_ff <= PH_CMD;
                    end
                end
                default: phase_ff <= PH_CMD;
            endcase
        end
    end

    // Outlives chip select high, so a commit still lands after the frame ends
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_tg_s <= 1'b0;
            wr_addr_s <= 6'h00;
            wr_data_s <= 16'h0000;
        end else if (phase_ff == PH_CMD && bit_cnt_ff == 3'd7) begin
            wr_addr_s <= {cmd_sh_ff[4:0], din};
        end else if (phase_ff == PH_WRITE && rx_left_ff == 5'd1) begin
            wr_data_s <= {rx_sh_ff[14:0], din};
            wr_tg_s <= ~wr_tg_s;
        end
    end

    // Data out changes on rising sclk
    always_ff @(posedge sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            tx_sh_ff <= 24'h000000;
            out_left_ff <= 5'd0;
            drive_ff <= 1'b0;
        end else if (read_load) begin
            // Whole register captured at once, first bit out on this edge
            tx_sh_ff <= snap_all_ff[wr_addr_s] << (5'd24 - reg_bits(wr_addr_s));
            out_left_ff <= reg_bits(wr_addr_s);
            drive_ff <= 1'b1;
        end else if (drive_ff && out_left_ff > 5'd1) begin
            tx_sh_ff <= {tx_sh_ff[22:0], 1'b0};
            out_left_ff <= out_left_ff - 5'd1;
        end else if (phase_ff != PH_READ) begin
            drive_ff <= 1'b0;
            out_left_ff <= 5'd0;
        end
    end

    // Clear request must not fall back when chip select rises, or mclk sees a second toggle
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            clr_tg_s <= 1'b0;
            clr_addr_s <= 6'h00;
        end else if (read_load) begin
            clr_addr_s <= wr_addr_s;
            clr_tg_s <= ~clr_tg_s;
        end
    end

    assign dout_o = tx_sh_ff[23];
    assign dout_oe = drive_ff & ~last_fall_ff & ~cs_b;
endmodule : meter_serial_port

// file: core/meter_map.svh
// Purpose: offsets, reset values, field positions and timing counts of the meter serial port
// Assumes: addresses are 6-bit register numbers carried in the command byte
// Notes: included by the serial port module
// Behaviour
// - Each read data bit appears on a rising serial clock edge.
// - Output leaves high impedance on the rising edge after a read command.
// - After the last bit, port returns to command mode and releases output on falling edge.
// - Chip select rising aborts a read and floats the output at once.
// - Addressed register is copied whole into the shift register at once.
// - Waveform register holds source chosen by config bits 14 and 13.
// - Active power integrates into a 24-bit signed energy accumulator.
// - Clear-on-read active energy view returns the value then zeroes the accumulator.
// - Line-cycle active energy accumulates over programmed half line cycles.
// - Apparent power accumulates unsigned 24-bit; a line-cycle apparent view exists too.
// - Clear-on-read apparent energy view returns value then zeroes the accumulator.
// - Enable bits gate the interrupt; flags still set; enable resets to 0x40.
// - Status reports events; clear-on-read view clears all flags after read.
// - Current offset bits 0-5, bit 6 unused, MSB enables integrator, resets 0.
// - Voltage offset bits 0-5, bits 6-7 unused, sign is inverted.
// - Phase calibration is 6-bit two's complement, resets to 0x0D.
// - Active power offset register corrects the active power result.
// - Configuration register is readable anytime and resets to 0x000C.
// - Gain register selects amplifier gain for both channels.
// - Chip select falling resets the port into command-waiting mode.
// - Command byte: address in six low bits, MSB selects write.
`ifndef METER_MAP_SVH
`define METER_MAP_SVH
`define ADDR_WAVEFORM 6'h01
`define ADDR_AENG 6'h02
`define ADDR_AENG_COR 6'h03
`define ADDR_LAENG 6'h04
`define ADDR_VAENG 6'h05
`define ADDR_VAENG_COR 6'h06
`define ADDR_LVAENG 6'h07
`define ADDR_CONFIG 6'h09
`define ADDR_EVT_EN 6'h0A
`define ADDR_EVT_FLAGS 6'h0B
`define ADDR_EVT_FLAGS_COR 6'h0C
`define ADDR_CUR_OFS 6'h0D
`define ADDR_VOLT_OFS 6'h0E
`define ADDR_GAIN 6'h0F
`define ADDR_PHASE_CALIBRATION 6'h10
`define ADDR_APOFS 6'h11
`define RST_CONFIG 16'h000C
`define RST_EVT_EN 16'h0040
`define RST_PHASE_CALIBRATION 6'h0D
`define CFG_WAVSRC_HI 14
`define CFG_WAVSRC_LO 13
`define CMD_WRITE_BIT 7
`define CUR_OFS_INTEG_BIT 7
`define WRITE_GAP_NS 4000
`define MCLK_PERIOD_NS 100
`define WRITE_GAP_CYC ((`WRITE_GAP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// file: core/meter_pkg.sv
// Purpose: types shared by the meter serial port
// Assumes: constants live in meter_map.svh
// Notes: none
package meter_pkg;
    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_READ = 2'b01,
        PH_WRITE = 2'b10,
        PH_IDLE = 2'b11
    } port_phase_t;
    typedef logic [23:0] word24_t;
    typedef logic [15:0] flags_t;
endpackage : meter_pkg

// file: sim/meter_serial_port_monitor.sv
// Purpose: pin-level checks on the meter serial port
// Assumes: host idles sclk high and shifts bits on falling edges
// Notes: link counter clears while cs_b is high, so aborts restart it
`timescale 1ns/1ps
module meter_serial_port_monitor (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic sclk, // Serial clock
    input wire logic cs_b, // Chip select, active low
    input wire logic din, // Serial data in
    input wire logic dout_o, // Serial data out
    input wire logic dout_oe, // Data out enable
    input wire logic [15:0] event_set, // Event pulses
    input wire logic irq_b, // Interrupt, active low
    input wire logic [15:0] config_o, // Configuration
    input wire logic [5:0] phase_cal, // Phase calibration
    input wire logic [7:0] amp_gain, // Gain selection
    input wire logic signed [15:0] ap_offset // Power offset
);
    logic [5:0] fall_cnt;
    logic [7:0] cmd_sh;
    function automatic int blen(input logic [5:0] a);
        if (a >= 6'h01 && a <= 6'h07) return 24;
        if ((a >= 6'h09 && a <= 6'h0C) || a == 6'h11) return 16;
        if (a >= 6'h08 && a <= 6'h10) return 8;
        return 0;
    endfunction : blen
    // Saturates so a stuck clock never wraps into a fake command phase
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            fall_cnt <= 6'h00;
            cmd_sh <= 8'h00;
        end else begin
            fall_cnt <= (fall_cnt == 6'h3F) ? fall_cnt : fall_cnt + 6'h01;
            if (fall_cnt < 6'h08) begin
                cmd_sh <= {cmd_sh[6:0], din};
            end
        end
    end
    property p_cs_float;
        @(posedge mclk) disable iff (!rst_b) cs_b |-> !dout_oe;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("dout driven while deselected");
    property p_cmd_float;
        @(negedge sclk) disable iff (cs_b || !rst_b) fall_cnt < 6'h08 |-> !dout_oe;
    endproperty
    a_cmd_float: assert property (p_cmd_float) else $error("dout driven during command");
    property p_read_drive;
        @(negedge sclk) disable iff (cs_b || !rst_b)
            (fall_cnt >= 6'h08 && fall_cnt < 8 + blen(cmd_sh[5:0]) && !cmd_sh[7] && blen(cmd_sh[5:0]) != 0)
            |-> dout_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("dout not driven in read");
    property p_read_release;
        @(posedge sclk) disable iff (cs_b || !rst_b)
            (fall_cnt == 8 + blen(cmd_sh[5:0]) && !cmd_sh[7] && blen(cmd_sh[5:0]) != 0) |-> !dout_oe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("dout held after last bit");
    property p_write_float;
        @(negedge sclk) disable iff (cs_b || !rst_b) (fall_cnt >= 6'h08 && cmd_sh[7]) |-> !dout_oe;
    endproperty
    a_write_float: assert property (p_write_float) else $error("dout driven in write");
    property p_pad_zero;
        @(negedge sclk) disable iff (cs_b || !rst_b)
            ((fall_cnt == 6'h08 || fall_cnt == 6'h09) && cmd_sh == 8'h10) |-> (dout_oe && !dout_o);
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");
    property p_reset_vals;
        @(posedge mclk) disable iff (!rst_b) $rose(rst_b) |-> (config_o == 16'h000C && phase_cal == 6'h0D && irq_b);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
    property p_regs_quiet;
        @(posedge mclk) disable iff (!rst_b)
            (cs_b && $past(cs_b, 8)) |-> ($stable(config_o) && $stable(amp_gain) && $stable(ap_offset));
    endproperty
    a_regs_quiet: assert property (p_regs_quiet) else $error("register moved without access");
    property p_irq_quiet;
        @(posedge mclk) disable iff (!rst_b)
            (cs_b && $past(cs_b, 8) && event_set == 16'h0000 && $past(event_set) == 16'h0000
            && $past(event_set, 2) == 16'h0000) |-> $stable(irq_b);
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq moved without cause");
endmodule : meter_serial_port_monitor
bind meter_serial_port meter_serial_port_monitor u_mon (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .event_set(event_set), .irq_b(irq_b), .config_o(config_o),
    .phase_cal(phase_cal), .amp_gain(amp_gain), .ap_offset(ap_offset));

// file: sim/meter_host_model.sv
// Purpose: host controller driving the serial port frames
// Assumes: 125 ns serial clock, stopped high between frames
// Notes: data bits are sampled just before each falling edge
`timescale 1ns/1ps
module meter_host_model (
    output logic sclk, // Serial clock, idles high
    output logic cs_b, // Chip select, active low
    output logic din, // Serial data to device
    input wire logic sdo // Resolved serial data line
);
    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
    end
    // Fewer data bits than the register width aborts the read
    task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [23:0] wdata, output logic [23:0] rdata);
        logic [31:0] sh;
        sh = {cmd, wdata << (24 - nbits)};
        rdata = 24'h000000;
        #37;
        cs_b = 1'b0;
        #100;
        for (int i = 0; i < 8 + nbits; i++) begin
            din = (i < 8 || cmd[7]) ? sh[31 - i] : ~din;
            #62.5;
            if (i >= 8) begin
                rdata = {rdata[22:0], sdo};
            end
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
        end
        #62.5;
        cs_b = 1'b1;
        if (cmd[7]) begin
            #4000;
        end
        #200;
    endtask : xfer
endmodule : meter_host_model

// file: sim/tb_meter_serial_port.sv
// Purpose: register-level test of the meter serial port
// Assumes: energy adds one power value per sample strobe
// Notes: a released dout reads as the inverse of its last value
`timescale 1ns/1ps
module tb_meter_serial_port;
    logic mclk = 1'b0;
    logic rst_b, sclk, cs_b, din, dout_o, dout_oe, sdo, sample_stb, half_cycle_stb, irq_b, integrator_en;
    logic [23:0] cur_sample, volt_sample, apparent_power, v;
    logic signed [23:0] active_power;
    logic [15:0] line_cycle_count, event_set, config_o;
    logic [5:0] cur_offset, volt_offset, phase_cal;
    logic [7:0] amp_gain;
    logic signed [15:0] ap_offset;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [5:0] ra [9] = '{6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h02, 6'h0B};
    int rn [9] = '{16, 16, 8, 8, 8, 8, 16, 24, 16};
    logic [23:0] rv [9] = '{24'h00000C, 24'h000040, 24'h0, 24'h0, 24'h0, 24'h00000D, 24'h0, 24'h0, 24'h0};
    logic [23:0] wexp [4] = '{24'hFF8011, 24'h000000, 24'h123456, 24'h654321};
    always #50 mclk = ~mclk;
    assign sdo = dout_oe ? dout_o : ~dout_o;
    meter_serial_port DUT (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout_o(dout_o),
        .dout_oe(dout_oe), .sample_stb(sample_stb), .cur_sample(cur_sample), .volt_sample(volt_sample),
        .active_power(active_power), .apparent_power(apparent_power), .half_cycle_stb(half_cycle_stb),
        .line_cycle_count(line_cycle_count), .event_set(event_set), .irq_b(irq_b), .config_o(config_o),
        .cur_offset(cur_offset), .integrator_en(integrator_en), .volt_offset(volt_offset), .amp_gain(amp_gain),
        .phase_cal(phase_cal), .ap_offset(ap_offset));
    meter_host_model u_host (.sclk(sclk), .cs_b(cs_b), .din(din), .sdo(sdo));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [5:0] a, input int n, output logic [23:0] d);
        u_host.xfer({2'b00, a}, n, 24'h000000, d);
    endtask : rd
    task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
        logic [23:0] unused;
        u_host.xfer({2'b10, a}, n, d, unused);
    endtask : wr
    task automatic tick(input logic [15:0] ev, input logic stb);
        @(posedge mclk);
        event_set <= ev;
        sample_stb <= stb;
        half_cycle_stb <= stb;
        @(posedge mclk);
        event_set <= 16'h0000;
        sample_stb <= 1'b0;
        half_cycle_stb <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : tick
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // Whole run needs about 2000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        {sample_stb, half_cycle_stb, event_set} = '0;
        cur_sample = 24'h123456;
        volt_sample = 24'h654321;
        active_power = 24'sh000010;
        apparent_power = 24'h000020;
        line_cycle_count = 16'h0002;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], rn[i], v);
            check(v, rv[i]);
        end
        rd(6'h08, 8, v);
        check(v, 24'h000000);
        wr(6'h0F, 8, 24'h0000A5);
        rd(6'h0F, 8, v);
        check(v, 24'h0000A5);
        check({16'h0000, amp_gain}, 24'h0000A5);
        wr(6'h0D, 8, 24'h000085);
        check({17'h00000, integrator_en, cur_offset}, 24'h000045);
        wr(6'h0E, 8, 24'h000003);
        check({18'h00000, volt_offset}, 24'h00003D);
        wr(6'h10, 8, 24'h000021);
        rd(6'h10, 8, v);
        check(v, 24'h000021);
        check({18'h00000, phase_cal}, 24'h000021);
        wr(6'h11, 16, 24'h008001);
        check({8'h00, ap_offset}, 24'h008001);
        rd(6'h11, 5, v);
        check({23'h000000, dout_oe}, 24'h000000);
        rd(6'h11, 16, v);
        check(v, 24'h008001);
        repeat (4) tick(16'h0000, 1'b1);
        rd(6'h02, 24, v);
        check(v, 24'hFE0044);
        rd(6'h04, 24, v);
        check(v, 24'hFF0022);
        rd(6'h07, 24, v);
        check(v, 24'h000040);
        wr(6'h02, 24, 24'hFFFFFF);
        rd(6'h03, 24, v);
        check(v, 24'hFE0044);
        rd(6'h02, 24, v);
        check(v, 24'h000000);
        rd(6'h05, 24, v);
        check(v, 24'h000080);
        rd(6'h06, 24, v);
        check(v, 24'h000080);
        rd(6'h05, 24, v);
        check(v, 24'h000000);
        for (int k = 0; k < 4; k++) begin
            wr(6'h09, 16, {9'h000, k[1:0], 13'h0000});
            tick(16'h0000, 1'b1);
            rd(6'h01, 24, v);
            check(v, wexp[k]);
        end
        check({8'h00, config_o}, 24'h006000);
        tick(16'h0001, 1'b0);
        check({23'h000000, irq_b}, 24'h000001);
        rd(6'h0B, 16, v);
        check(v, 24'h000001);
        tick(16'h0040, 1'b0);
        check({23'h000000, irq_b}, 24'h000000);
        rd(6'h0C, 16, v);
        check(v, 24'h000041);
        rd(6'h0B, 16, v);
        check(v, 24'h000000);
        check({23'h000000, irq_b}, 24'h000001);
        wr(6'h0A, 16, 24'h000001);
        tick(16'h0040, 1'b0);
        check({23'h000000, irq_b}, 24'h000001);
        rd(6'h0B, 16, v);
        check(v, 24'h000040);
        final_report();
    end
endmodule : tb_meter_serial_port
